/* File: core/mii_phy_port.sv */
// MII port, strap capture, status indicators and register slave
//
// Function
// - Fiber strap low selects 100 Mbps fiber
// - Standard: fast LED low at 100
// - Standard: transmit LED toggles while transmitting
// - Clock strap low enables 25 MHz output
// - Standard: slow LED low at 10
// - Standard: duplex LED low at full
// - Advanced: LEDs form two bi-colour pairs
// - Speed from registers or auto-negotiation
// - Full and half duplex at both speeds
// - Management stays reachable in every mode
// - Nibble taken each transmit period with enable
// - Transmit clock runs continuously
// - Transmit error forces invalid symbol
// - Receive nibble presented each valid period
// - Receive clock runs while link up
// - Data valid spans frame, not end delimiter
// - Receive error held at least one period
// - Carrier sense while either medium busy
// - Receive LED strap low selects advanced
`timescale 1ns/1ps
module mii_phy_port #(
  parameter int BLINK_CYCLES = mii_phy_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // MII transmit
  output logic o_tx_clk,
  input wire logic i_tx_en,
  input wire logic [3:0] i_txd,
  input wire logic i_tx_er,
  // MII receive
  output logic o_rx_clk,
  output logic o_rx_dv,
  output logic [3:0] o_rxd,
  output logic o_rx_er,
  output logic o_crs,
  output logic o_col,
  // Media side, same clock
  input wire logic i_link_up,
  input wire logic i_an_done,
  input wire logic i_an_speed100,
  input wire logic i_an_full,
  input wire logic i_rx_media_active,
  input wire logic i_rx_frame,
  input wire logic i_rx_sym_valid,
  input wire logic [3:0] i_rx_sym_data,
  input wire logic i_rx_sym_err,
  output logic o_tx_sym_valid,
  output logic [3:0] o_tx_sym_data,
  output logic o_tx_sym_invalid,
  output logic o_fiber_mode,
  // Strap and indicator pins
  input wire logic i_fast_speed_led_fiber_strap,
  output logic o_fast_speed_led_fiber_strap,
  output logic o_fast_speed_led_fiber_strap_oe,
  input wire logic i_slow_speed_led_clkout_strap,
  output logic o_slow_speed_led_clkout_strap,
  output logic o_slow_speed_led_clkout_strap_oe,
  input wire logic i_rx_led_config_strap,
  output logic o_rx_led_config_strap,
  output logic o_rx_led_config_strap_oe,
  output logic o_tx_activity_led_pair_b,
  output logic o_duplex_led_pair_b,
  output logic o_ref_clock_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [mii_phy_pkg::SYNC_W-1:0] sync_meta;
  logic [mii_phy_pkg::SYNC_W-1:0] sync_pin;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_meta <= '0;
      sync_pin <= '0;
    end else begin
      sync_meta <= {i_rx_led_config_strap, i_slow_speed_led_clkout_strap,
                    i_fast_speed_led_fiber_strap, i_tx_er, i_tx_en, i_txd};
      sync_pin <= sync_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release
  logic [1:0] settle;
  logic straps_done;
  logic fiber_sel;
  logic clkout_en;
  logic adv_led;

  // Pins stay undriven until taken so the pull resistors set the level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      settle <= 2'h0;
      straps_done <= 1'b0;
      fiber_sel <= 1'b0;
      clkout_en <= 1'b0;
      adv_led <= 1'b0;
    end else if (!straps_done) begin
      settle <= settle + 2'h1;
      if (settle == mii_phy_pkg::STRAP_SETTLE) begin
        straps_done <= 1'b1;
        fiber_sel <= !sync_pin[mii_phy_pkg::S_FIBER];
        clkout_en <= !sync_pin[mii_phy_pkg::S_CLKOUT];
        adv_led <= !sync_pin[mii_phy_pkg::S_LEDCFG];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers over AHB-Lite
  logic [mii_phy_pkg::CTRL_W-1:0] ctrl;
  logic [mii_phy_pkg::PAT_W-1:0] led_pat;
  logic [31:0] status;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic addr_ok;
  logic [31:0] rd_val;
  logic speed100;
  logic full_dx;
  logic tx_active;

  // No wait states, so the bus stays usable whatever the data interface mode
  assign o_hreadyout = 1'b1;
  assign o_hresp = mii_phy_pkg::HRESP_OKAY;
  assign addr_ok = i_hsel && i_hready && i_htrans == mii_phy_pkg::HTRANS_NONSEQ;

  always_comb begin
    status = '0;
    status[mii_phy_pkg::ST_FIBER] = fiber_sel;
    status[mii_phy_pkg::ST_CLKOUT] = clkout_en;
    status[mii_phy_pkg::ST_ADVLED] = adv_led;
    status[mii_phy_pkg::ST_SPD100] = speed100;
    status[mii_phy_pkg::ST_FULL] = full_dx;
    status[mii_phy_pkg::ST_LINK] = i_link_up;
    status[mii_phy_pkg::ST_TXACT] = tx_active;
    status[mii_phy_pkg::ST_RXACT] = i_rx_media_active;
  end

  always_comb begin
    unique case (i_haddr[7:0])
      mii_phy_pkg::CTRL_OFS: rd_val = {29'h0, ctrl};
      mii_phy_pkg::STATUS_OFS: rd_val = status;
      mii_phy_pkg::LED_PAT_OFS: rd_val = {19'h0, led_pat};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0;
    end else if (addr_ok && !i_hwrite) begin
      o_hrdata <= rd_val;
    end
  end

  // Only whole-word writes change state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      wr_pend <= addr_ok && i_hwrite && i_hsize == mii_phy_pkg::HSIZE_WORD;
      wr_addr <= i_haddr[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= mii_phy_pkg::CTRL_RESET;
      led_pat <= mii_phy_pkg::PAT_RESET;
    end else if (wr_pend) begin
      if (wr_addr == mii_phy_pkg::CTRL_OFS) begin
        ctrl <= i_hwdata[mii_phy_pkg::CTRL_W-1:0];
      end
      if (wr_addr == mii_phy_pkg::LED_PAT_OFS) begin
        led_pat <= i_hwdata[mii_phy_pkg::PAT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed and duplex resolution
  logic use_an;

  // Fiber has no auto-negotiation, so it takes the manual duplex
  assign use_an = ctrl[mii_phy_pkg::CTRL_AN_EN] && i_an_done && !fiber_sel;
  assign speed100 = fiber_sel || (use_an ? i_an_speed100 : ctrl[mii_phy_pkg::CTRL_SPD100]);
  assign full_dx = use_an ? i_an_full : ctrl[mii_phy_pkg::CTRL_FULL];
  assign o_fiber_mode = fiber_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock divider
  logic [3:0] div_cnt;
  logic [3:0] half;
  logic div_wrap;
  logic tx_rise;
  logic tx_fall;

  assign half = speed100 ? mii_phy_pkg::FAST_HALF : mii_phy_pkg::SLOW_HALF;
  assign div_wrap = div_cnt >= half - 4'h1;
  assign tx_rise = div_wrap && !o_tx_clk;
  assign tx_fall = div_wrap && o_tx_clk;

  // Free running from reset; a speed change only reshapes the current half
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 4'h0;
      o_tx_clk <= 1'b0;
      o_rx_clk <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
      if (div_wrap) begin
        o_tx_clk <= !o_tx_clk;
      end
      // Gated copy, so it may lose a half period at link change
      o_rx_clk <= (div_wrap ? !o_tx_clk : o_tx_clk) && i_link_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit path
  // Taken at the rising edge; the synchroniser makes it the nibble of the last period
  assign tx_active = sync_pin[mii_phy_pkg::S_TXEN];

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tx_sym_valid <= 1'b0;
      o_tx_sym_data <= 4'h0;
      o_tx_sym_invalid <= 1'b0;
    end else begin
      o_tx_sym_valid <= tx_rise && tx_active;
      if (tx_rise) begin
        o_tx_sym_data <= sync_pin[mii_phy_pkg::S_TXD+3:mii_phy_pkg::S_TXD];
        o_tx_sym_invalid <= tx_active && sync_pin[mii_phy_pkg::S_TXER];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path, updated on the falling edge so the MAC samples mid period
  logic [3:0] rx_hold;
  logic err_pend;
  logic err_set;
  logic rx_upd;

  assign err_set = i_rx_frame && i_rx_sym_err;
  assign rx_upd = tx_fall;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_hold <= 4'h0;
    end else if (i_rx_sym_valid) begin
      rx_hold <= i_rx_sym_data;
    end
  end

  // An error arriving with the transfer is kept for the next period
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      err_pend <= 1'b0;
    end else begin
      err_pend <= (err_pend && !rx_upd) || err_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rx_dv <= 1'b0;
      o_rxd <= 4'h0;
      o_rx_er <= 1'b0;
    end else if (rx_upd) begin
      o_rx_dv <= i_rx_frame && i_link_up;
      o_rxd <= (i_rx_frame && i_link_up) ? rx_hold : 4'h0;
      o_rx_er <= err_pend && i_link_up;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carrier sense and collision
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_crs <= 1'b0;
      o_col <= 1'b0;
    end else begin
      o_crs <= tx_active || i_rx_media_active;
      o_col <= tx_active && i_rx_media_active && !full_dx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock output
  logic [3:0] ref_cnt;
  logic ref_wrap;

  assign ref_wrap = ref_cnt >= mii_phy_pkg::REF_HALF - 4'h1;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ref_cnt <= 4'h0;
      o_ref_clock_out <= 1'b0;
    end else if (!clkout_en) begin
      ref_cnt <= 4'h0;
      o_ref_clock_out <= 1'b0;
    end else begin
      ref_cnt <= ref_wrap ? 4'h0 : ref_cnt + 4'h1;
      if (ref_wrap) begin
        o_ref_clock_out <= !o_ref_clock_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicators
  logic [mii_phy_pkg::BLINK_W-1:0] blink_cnt;
  logic blink_tick;
  logic tx_led;
  logic rx_led;
  logic [1:0] pair_a;
  logic [1:0] pair_b;

  assign blink_tick = blink_cnt == mii_phy_pkg::BLINK_W'(BLINK_CYCLES - 1);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blink_cnt <= '0;
    end else begin
      blink_cnt <= blink_tick ? '0 : blink_cnt + 1'b1;
    end
  end

  // Activity LEDs idle high (off) and toggle at the blink rate while busy
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_led <= 1'b1;
      rx_led <= 1'b1;
    end else begin
      if (!tx_active) begin
        tx_led <= 1'b1;
      end else if (blink_tick) begin
        tx_led <= !tx_led;
      end
      if (!i_rx_media_active) begin
        rx_led <= 1'b1;
      end else if (blink_tick) begin
        rx_led <= !rx_led;
      end
    end
  end

  // Pair A shows speed, pair B duplex; transmit activity blanks A and receive activity blanks B to their off code
  always_comb begin
    if (!i_link_up || (led_pat[mii_phy_pkg::PAT_BLINK] && !tx_led)) begin
      pair_a = led_pat[mii_phy_pkg::PAT_AOFF+:2];
    end else if (speed100) begin
      pair_a = led_pat[mii_phy_pkg::PAT_A100+:2];
    end else begin
      pair_a = led_pat[mii_phy_pkg::PAT_A10+:2];
    end
    if (!i_link_up || (led_pat[mii_phy_pkg::PAT_BLINK] && !rx_led)) begin
      pair_b = led_pat[mii_phy_pkg::PAT_BOFF+:2];
    end else if (full_dx) begin
      pair_b = led_pat[mii_phy_pkg::PAT_BFULL+:2];
    end else begin
      pair_b = led_pat[mii_phy_pkg::PAT_BHALF+:2];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fast_speed_led_fiber_strap <= 1'b1;
      o_slow_speed_led_clkout_strap <= 1'b1;
      o_tx_activity_led_pair_b <= 1'b1;
      o_duplex_led_pair_b <= 1'b1;
      o_rx_led_config_strap <= 1'b1;
    end else if (adv_led) begin
      o_fast_speed_led_fiber_strap <= pair_a[1];
      o_tx_activity_led_pair_b <= pair_a[0];
      o_slow_speed_led_clkout_strap <= pair_b[1];
      o_duplex_led_pair_b <= pair_b[0];
      o_rx_led_config_strap <= rx_led;
    end else begin
      o_fast_speed_led_fiber_strap <= !speed100;
      o_slow_speed_led_clkout_strap <= speed100;
      o_duplex_led_pair_b <= !full_dx;
      o_tx_activity_led_pair_b <= tx_led;
      o_rx_led_config_strap <= rx_led;
    end
  end

  assign o_fast_speed_led_fiber_strap_oe = straps_done;
  assign o_slow_speed_led_clkout_strap_oe = straps_done;
  assign o_rx_led_config_strap_oe = straps_done;

endmodule

/* File: include/mii_phy_pkg.sv */
// Constants shared by the MII port, strap and indicator logic
package mii_phy_pkg;
  // Clock rates
  localparam int CLK_HZ = 50_000_000;
  localparam int FAST_LINK_HZ = 25_000_000;
  localparam int SLOW_LINK_HZ = 2_500_000;
  localparam int REF_OUT_HZ = 25_000_000;
  // Half periods in system cycles
  localparam logic [3:0] FAST_HALF = 4'(CLK_HZ / (2 * FAST_LINK_HZ));
  localparam logic [3:0] SLOW_HALF = 4'(CLK_HZ / (2 * SLOW_LINK_HZ));
  localparam logic [3:0] REF_HALF = 4'(CLK_HZ / (2 * REF_OUT_HZ));
  // Indicator blink half period
  localparam int BLINK_MS = 50;
  localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;
  localparam int BLINK_W = 22;
  // Cycles after reset release before straps are taken
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Synchronised pin vector layout
  localparam int SYNC_W = 9;
  localparam int S_TXD = 0;
  localparam int S_TXEN = 4;
  localparam int S_TXER = 5;
  localparam int S_FIBER = 6;
  localparam int S_CLKOUT = 7;
  localparam int S_LEDCFG = 8;
  // Register offsets (low address byte)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LED_PAT_OFS = 8'h08;
  // Control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_AN_EN = 0;
  localparam int CTRL_SPD100 = 1;
  localparam int CTRL_FULL = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;
  // Advanced pattern fields, two bits each except the one-bit blink enable: {first pin, second pin}
  localparam int PAT_W = 13;
  localparam int PAT_A100 = 0;
  localparam int PAT_A10 = 2;
  localparam int PAT_AOFF = 4;
  localparam int PAT_BFULL = 6;
  localparam int PAT_BHALF = 8;
  localparam int PAT_BOFF = 10;
  localparam int PAT_BLINK = 12;
  localparam logic [PAT_W-1:0] PAT_RESET = 13'h1e79;
  // Status fields
  localparam int ST_FIBER = 0;
  localparam int ST_CLKOUT = 1;
  localparam int ST_ADVLED = 2;
  localparam int ST_SPD100 = 3;
  localparam int ST_FULL = 4;
  localparam int ST_LINK = 5;
  localparam int ST_TXACT = 6;
  localparam int ST_RXACT = 7;
  // AHB-Lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

/* File: verification/mii_mac_model.sv */
// Behavioural MAC on the far side of the MII
`timescale 1ns/1ps
module mii_mac_model (
  // Bench system clock
  input wire logic i_clk,
  // MII pins seen from the MAC
  input wire logic i_tx_clk,
  input wire logic i_rx_clk,
  input wire logic i_rx_dv,
  input wire logic [3:0] i_rxd,
  input wire logic i_rx_er,
  output logic o_tx_en,
  output logic [3:0] o_txd,
  output logic o_tx_er
);
  logic tx_q;
  logic rx_q;
  logic [3:0] sent_q[$];
  logic [3:0] got_q[$];
  int n_er;
  initial begin
    o_tx_en = 1'b0;
    o_txd = 4'h0;
    o_tx_er = 1'b0;
  end
  // Pins are taken where the receive clock rises
  always @(posedge i_clk) begin
    tx_q <= i_tx_clk;
    rx_q <= i_rx_clk;
    if (i_rx_clk && !rx_q && i_rx_dv) begin
      got_q.push_back(i_rxd);
    end
    if (i_rx_clk && !rx_q && i_rx_er) begin
      n_er++;
    end
  end
  // One nibble per transmit period, moved just after its rise
  task automatic send(input int len, input int err_at);
    int i;
    logic [3:0] d;
    i = 0;
    while (i <= len) begin
      @(posedge i_clk);
      if (i_tx_clk && !tx_q) begin
        d = 4'($urandom);
        if (i < len) begin
          sent_q.push_back(d);
        end
        o_tx_en <= i < len;
        o_txd <= (i < len) ? d : ~o_txd;
        o_tx_er <= i == err_at;
        i++;
      end
    end
  endtask
endmodule

/* File: verification/mii_phy_port_asserts.sv */
// Concurrent checks on the MII port, strap and indicator pins
`timescale 1ns/1ps
module mii_phy_port_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Watched pins
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_tx_clk,
  input wire logic i_tx_en,
  input wire logic o_rx_clk,
  input wire logic o_rx_dv,
  input wire logic [3:0] o_rxd,
  input wire logic o_rx_er,
  input wire logic o_crs,
  input wire logic o_col,
  input wire logic i_link_up,
  input wire logic i_rx_media_active,
  input wire logic o_tx_sym_valid,
  input wire logic o_tx_sym_invalid,
  input wire logic o_fiber_mode,
  input wire logic i_fast_speed_led_fiber_strap,
  input wire logic o_fast_speed_led_fiber_strap,
  input wire logic o_fast_speed_led_fiber_strap_oe,
  input wire logic i_slow_speed_led_clkout_strap,
  input wire logic o_slow_speed_led_clkout_strap,
  input wire logic i_rx_led_config_strap,
  input wire logic o_rx_led_config_strap_oe,
  input wire logic o_ref_clock_out
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] age;
  logic cap_fib;
  logic cap_clk;
  logic cap_led;
  wire cfg = age == 2'h3;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      age <= 2'h0;
    end else if (o_rx_led_config_strap_oe && !cfg) begin
      age <= age + 2'h1;
    end
  end
  // Pins read as straps only while nobody drives them
  always_ff @(posedge i_clk) begin
    if (!o_rx_led_config_strap_oe) begin
      cap_fib <= i_fast_speed_led_fiber_strap;
      cap_clk <= i_slow_speed_led_clkout_strap;
      cap_led <= i_rx_led_config_strap;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_OE_HOLD: assert property ($past(o_rx_led_config_strap_oe) |->
    o_rx_led_config_strap_oe && o_fast_speed_led_fiber_strap_oe) else $error("strap oe dropped");
  AST_FIBER: assert property (cfg |-> o_fiber_mode == !cap_fib)
    else $error("fiber mode differs from strap");
  AST_REF_ON: assert property (cfg && !cap_clk |-> o_ref_clock_out != $past(o_ref_clock_out))
    else $error("reference clock not toggling");
  AST_REF_OFF: assert property (cfg && cap_clk |-> !o_ref_clock_out)
    else $error("reference clock active");
  AST_FX_RATE: assert property (cfg && o_fiber_mode && $rose(o_tx_clk) |=>
    !o_tx_clk ##1 o_tx_clk) else $error("transmit clock not at fast rate");
  AST_STD_SPEED: assert property (cfg && cap_led |->
    o_fast_speed_led_fiber_strap != o_slow_speed_led_clkout_strap) else $error("speed leds");
  AST_SYM_TIME: assert property (o_tx_sym_valid |-> o_tx_clk && !$past(o_tx_clk))
    else $error("symbol not after transmit clock rise");
  AST_RXD_IDLE: assert property (!o_rx_dv |-> o_rxd == 4'h0)
    else $error("receive data without valid");
  AST_RX_EDGE: assert property (i_link_up && $past(i_link_up) &&
    $changed({o_rx_dv, o_rxd, o_rx_er}) |-> !o_tx_clk) else $error("receive pins moved early");
  AST_NO_LINK: assert property (!i_link_up [*2] |-> !o_rx_clk)
    else $error("receive clock without link");
  AST_CRS_RX: assert property ($past(i_rx_media_active) |-> o_crs)
    else $error("carrier missing");
  AST_CRS_IDLE: assert property (!$past(i_rx_media_active) && !$past(i_tx_en, 2) &&
    !$past(i_tx_en, 3) && !$past(i_tx_en, 4) |-> !o_crs) else $error("carrier while idle");
  AST_COL: assert property (o_col |-> o_crs)
    else $error("collision without carrier");
  AST_BUS: assert property (o_hreadyout && !o_hresp)
    else $error("bus not ready");
  CV_TX_ERR: cover property (o_tx_sym_valid && o_tx_sym_invalid);
  CV_RX_ERR: cover property (o_rx_er);
  CV_ADV: cover property (cfg && !cap_led);
endmodule

/* File: verification/phy_mii_port_and_status_leds_tb_top.sv */
// Self-checking bench for the MII port, straps and indicators
`timescale 1ns/1ps
module phy_mii_port_and_status_leds_tb_top;
  logic i_clk, i_nrst, i_hsel, i_hwrite, i_tx_en, i_tx_er, i_link_up, i_an_done;
  logic i_an_speed100, i_an_full, i_rx_media_active, i_rx_frame, i_rx_sym_valid, i_rx_sym_err;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  logic [3:0] i_txd, i_rx_sym_data, o_rxd, o_tx_sym_data;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic o_hreadyout, o_hresp, o_tx_clk, o_rx_clk, o_rx_dv, o_rx_er, o_crs, o_col;
  logic o_tx_sym_valid, o_tx_sym_invalid, o_fiber_mode, o_tx_activity_led_pair_b;
  logic o_duplex_led_pair_b, o_ref_clock_out, o_fast_speed_led_fiber_strap;
  logic o_fast_speed_led_fiber_strap_oe, o_slow_speed_led_clkout_strap;
  logic o_slow_speed_led_clkout_strap_oe, o_rx_led_config_strap, o_rx_led_config_strap_oe;
  logic s_fib, s_clk, s_led, clk_q, act_q, rled_q;
  logic [12:0] pat;
  logic [3:0] tx_d[$], rx_e[$];
  logic tx_i[$];
  int err_count, n_tests, cyc, run, half, tog, col_n, e, seed, rtog;
  // Strap resistors show through while the pins are not driven
  wire i_fast_speed_led_fiber_strap = o_fast_speed_led_fiber_strap_oe ?
    o_fast_speed_led_fiber_strap : s_fib;
  wire i_slow_speed_led_clkout_strap = o_slow_speed_led_clkout_strap_oe ?
    o_slow_speed_led_clkout_strap : s_clk;
  wire i_rx_led_config_strap = o_rx_led_config_strap_oe ? o_rx_led_config_strap : s_led;
  wire i_hready = o_hreadyout;
  mii_phy_port #(.BLINK_CYCLES(8)) i_dut (.*);
  mii_mac_model i_mac (.i_clk, .i_tx_clk(o_tx_clk), .i_rx_clk(o_rx_clk), .i_rx_dv(o_rx_dv),
    .i_rxd(o_rxd), .i_rx_er(o_rx_er), .o_tx_en(i_tx_en), .o_txd(i_txd), .o_tx_er(i_tx_er));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    clk_q <= o_tx_clk;
    act_q <= o_tx_activity_led_pair_b;
    rled_q <= o_rx_led_config_strap;
    if (rled_q != o_rx_led_config_strap) rtog++;
    run <= (o_tx_clk !== clk_q) ? 1 : run + 1;
    if (o_tx_clk !== clk_q) half <= run;
    if (act_q !== o_tx_activity_led_pair_b) tog++;
    if (o_col === 1'b1) col_n++;
    if (o_tx_sym_valid === 1'b1) begin
      tx_d.push_back(o_tx_sym_data);
      tx_i.push_back(o_tx_sym_invalid);
    end
    // Whole run is well under this
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic reset(input logic [2:0] st);
    {s_fib, s_clk, s_led} <= st;
    i_nrst <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (12) @(posedge i_clk);
  endtask
  // Single word transfer, the answer awaited on hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    i_hsel <= 1'b1;
    i_htrans <= mii_phy_pkg::HTRANS_NONSEQ;
    i_haddr <= {24'h0, a};
    i_hwrite <= w;
    i_hsize <= mii_phy_pkg::HSIZE_WORD;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
  endtask
  function automatic logic [1:0] code(input int f);
    return 2'(pat >> f);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'h1a0f54b7);
    {i_nrst, i_hsel, i_hwrite, i_link_up, i_an_done, i_an_speed100, i_an_full} = 7'h0;
    {i_rx_media_active, i_rx_frame, i_rx_sym_valid, i_rx_sym_err} = 4'h0;
    {i_htrans, i_hsize, i_rx_sym_data, i_haddr, i_hwdata} = '0;
    reset(3'h7);
    i_link_up <= 1'b1;
    ahb(1'b0, mii_phy_pkg::CTRL_OFS, 32'h0);
    chk("ctrl reset", rd, 32'(mii_phy_pkg::CTRL_RESET));
    ahb(1'b0, mii_phy_pkg::LED_PAT_OFS, 32'h0);
    chk("pattern reset", rd, 32'(mii_phy_pkg::PAT_RESET));
    ahb(1'b1, mii_phy_pkg::STATUS_OFS, 32'hff);
    ahb(1'b0, mii_phy_pkg::STATUS_OFS, 32'h0);
    chk("straps", rd[2:0], 3'h0);
    ahb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("fiber mode", o_fiber_mode, 1'b0);
    chk("strap oe", o_slow_speed_led_clkout_strap_oe, 1'b1);
    for (int m = 0; m < 5; m++) begin
      logic sp;
      logic fu;
      sp = (m == 4) ? 1'($urandom) : m[0];
      fu = (m == 4) ? 1'($urandom) : m[1];
      // Manual rows offer the opposite speed to show it is ignored
      i_an_speed100 <= (m == 4) ? sp : !sp;
      i_an_full <= fu;
      i_an_done <= m == 4;
      ahb(1'b1, mii_phy_pkg::CTRL_OFS, (m == 4) ? 32'h1 : {29'h0, fu, sp, 1'b0});
      repeat (40) @(posedge i_clk);
      ahb(1'b0, mii_phy_pkg::STATUS_OFS, 32'h0);
      chk("speed", rd[3], sp);
      chk("duplex", rd[4], fu);
      chk("fast led", o_fast_speed_led_fiber_strap, !sp);
      chk("slow led", o_slow_speed_led_clkout_strap, sp);
      chk("duplex led", o_duplex_led_pair_b, !fu);
      chk("tx clk half", half, sp ? mii_phy_pkg::FAST_HALF : mii_phy_pkg::SLOW_HALF);
    end
    ahb(1'b1, mii_phy_pkg::CTRL_OFS, 32'h6);
    e = 2 + $urandom_range(7);
    tog = 0;
    i_mac.send(12, e);
    // Error flag without enable must not mark a symbol
    i_mac.send(4, 4);
    repeat (10) @(posedge i_clk);
    chk("tx count", tx_d.size(), 16);
    foreach (tx_d[k]) begin
      chk("tx nibble", tx_d[k], i_mac.sent_q[k]);
      chk("tx invalid", tx_i[k], k == e);
    end
    chk("tx led toggled", tog > 0, 1);
    ahb(1'b1, mii_phy_pkg::CTRL_OFS, 32'h2);
    i_rx_media_active <= 1'b1;
    e = $urandom_range(9);
    // Start just after a rise so each symbol is shown exactly once
    do @(posedge i_clk); while (o_tx_clk !== 1'b1);
    fork
      i_mac.send(8, 99);
      for (int k = 0; k < 10; k++) begin
        rx_e.push_back(4'($urandom));
        i_rx_frame <= 1'b1;
        i_rx_sym_valid <= 1'b1;
        i_rx_sym_data <= rx_e[k];
        i_rx_sym_err <= k == e;
        @(posedge i_clk);
        i_rx_sym_valid <= 1'b0;
        i_rx_sym_err <= 1'b0;
        @(posedge i_clk);
      end
    join
    i_rx_frame <= 1'b0;
    @(posedge i_clk);
    // Error outside a frame is not reported
    i_rx_sym_err <= 1'b1;
    @(posedge i_clk);
    i_rx_sym_err <= 1'b0;
    i_rx_media_active <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("rx count", i_mac.got_q.size(), 10);
    foreach (rx_e[k]) chk("rx nibble", i_mac.got_q[k], rx_e[k]);
    chk("rx errors", i_mac.n_er, 1);
    chk("collision seen", col_n > 0, 1);
    chk("rx led toggled", rtog > 0, 1);
    reset(3'h0);
    chk("fiber mode", o_fiber_mode, 1'b1);
    ahb(1'b0, mii_phy_pkg::STATUS_OFS, 32'h0);
    chk("straps", rd[2:0], 3'h7);
    pat = 13'($urandom);
    ahb(1'b1, mii_phy_pkg::LED_PAT_OFS, {19'h0, pat});
    for (int m = 0; m < 3; m++) begin
      ahb(1'b1, mii_phy_pkg::CTRL_OFS, (m == 0) ? 32'h4 : 32'h0);
      i_link_up <= m != 2;
      repeat (30) @(posedge i_clk);
      chk("pair a", {o_fast_speed_led_fiber_strap, o_tx_activity_led_pair_b},
        code((m == 2) ? mii_phy_pkg::PAT_AOFF : mii_phy_pkg::PAT_A100));
      chk("pair b", {o_slow_speed_led_clkout_strap, o_duplex_led_pair_b}, code((m == 0) ?
        mii_phy_pkg::PAT_BFULL : (m == 1) ? mii_phy_pkg::PAT_BHALF : mii_phy_pkg::PAT_BOFF));
    end
    stop_test();
  end
endmodule
bind mii_phy_port mii_phy_port_asserts i_chk (.i_clk, .i_nrst, .o_hreadyout, .o_hresp,
  .o_tx_clk, .i_tx_en, .o_rx_clk, .o_rx_dv, .o_rxd, .o_rx_er, .o_crs, .o_col, .i_link_up,
  .i_rx_media_active, .o_tx_sym_valid, .o_tx_sym_invalid, .o_fiber_mode,
  .i_fast_speed_led_fiber_strap, .o_fast_speed_led_fiber_strap,
  .o_fast_speed_led_fiber_strap_oe, .i_slow_speed_led_clkout_strap,
  .o_slow_speed_led_clkout_strap, .i_rx_led_config_strap, .o_rx_led_config_strap_oe,
  .o_ref_clock_out);
